// File: include/pfa_params.svh
// constants for the program flash access unit
`ifndef PFA_PARAMS_SVH
`define PFA_PARAMS_SVH

// page geometry
`define PFA_PAGE_WORDS      64
`define PFA_PAGE_LAST       6'h3f
`define PFA_ADDR_W          15
// flash operation select codes
`define PFA_OP_WRITE        3'h0
`define PFA_OP_ERASE        3'h1
`define PFA_OP_READ         3'h3
`define PFA_OP_ENABLE       3'h6
// table read takes two instruction cycles
`define PFA_TBL_CYCLES      2'h2
// flash array access latency in core clocks
`define PFA_READ_CYCLES     4'h4
`define PFA_WRITE_CYCLES    8'h40
`define PFA_ERASE_CYCLES    8'h40
// reset values
`define PFA_RST_BYTE        8'h00

`endif

// File: include/pfa_pkg.sv
// types for the program flash access unit
package pfa_pkg;

  typedef enum logic [2:0] {
    PFA_IDLE  = 3'b000,
    PFA_TBL   = 3'b001,
    PFA_READ  = 3'b010,
    PFA_WRITE = 3'b011,
    PFA_ERASE = 3'b100
  } pfa_state_e;

  // table read request from the core
  typedef struct packed {
    logic        valid;
    logic        extended;
    logic        sector0;
    logic [7:0]  dest_addr;
    logic [7:0]  ptr_low;
    logic [6:0]  ptr_high;
  } pfa_tbl_req_s;

  // flash control bits from software
  typedef struct packed {
    logic [2:0]  op_select;
    logic        enable_ok;
    logic        clear_enable;
    logic        write_start;
    logic        read_enable;
    logic        read_start;
  } pfa_ctrl_s;

  // flash array port
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic        erase;
    logic [14:0] addr;
    logic [15:0] wdata;
  } pfa_flash_s;

endpackage

// File: hdl/pfa_unit.sv
// program flash access unit: table reads, flash access, pin mux
//
// Overview of operation
// - table read puts low byte at destination, high byte in holder
// - plain reads target sector 0, extended reads any other sector
// - table address is pointer high joined with pointer low
// - every table instruction takes two instruction cycles, core stalls
// - erase and write by 64-word page, read by single word
// - enabled status set only after enable; buffer loads need it
// - write start launches page write, cleared by hardware at end
// - word reads only while read enable is set
// - read start launches a word read, cleared at completion
// - programming uses one two-way data pin and an external clock
// - debug mode disables other functions on the debug pins
// - debug pins still serve as programming pins
// - debug data pin is two-way, debug clock is input only
// - op codes: 000 write, 001 erase, 011 read, 110 enable
// - high byte write loads buffer, address increments, stops at page end
// - core halts while read, write or erase runs
`timescale 1ns/1ps
`include "pfa_params.svh"

module pfa_unit (
  // clock and reset
  input  wire logic                i_core_clk,
  input  wire logic                i_reset_n,
  // table read port
  input  wire pfa_pkg::pfa_tbl_req_s i_tbl_req,
  input  wire logic [15:0]         i_flash_rdata,
  output logic                     o_tbl_wr,
  output logic [7:0]               o_tbl_dest_addr,
  output logic [7:0]               o_tbl_low_byte,
  output logic [7:0]               o_table_high_byte_holder,
  output logic                     o_tbl_error,
  // flash control and status
  input  wire pfa_pkg::pfa_ctrl_s  i_ctrl,
  input  wire logic [14:0]         i_flash_addr,
  input  wire logic                i_flash_addr_load,
  input  wire logic [7:0]          i_data_low_byte,
  input  wire logic                i_data_high_byte_wr,
  input  wire logic [7:0]          i_data_high_byte_reg,
  output logic                     o_erase_write_enabled_status,
  output logic                     o_write_start_bit,
  output logic                     o_read_start_bit,
  output logic [14:0]              o_flash_addr,
  output logic [15:0]              o_read_data,
  output logic                     o_core_stall,
  // flash array
  output pfa_pkg::pfa_flash_s      o_flash,
  // programming and debug pins
  input  wire logic                i_debug_active,
  input  wire logic                i_prog_active,
  input  wire logic                i_prog_serial_data_pin,
  input  wire logic                i_prog_serial_clock_pin,
  input  wire logic                i_proto_data_out,
  input  wire logic                i_proto_data_oe,
  input  wire logic                i_func_data_out,
  input  wire logic                i_func_data_oe,
  input  wire logic                i_func_clock_out,
  input  wire logic                i_func_clock_oe,
  output logic                     o_debug_serial_data_pin,
  output logic                     o_debug_serial_data_oe,
  output logic                     o_debug_serial_clock_pin,
  output logic                     o_debug_serial_clock_oe,
  output logic                     o_proto_data_in,
  output logic                     o_proto_clock_in,
  output logic                     o_func_data_in,
  output logic                     o_func_clock_in
);
  import pfa_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    pfa_state_e  state;
    logic [7:0]  count;
    logic [7:0]  dest;
    logic        tbl_wr;
    logic [7:0]  low_byte;
    logic [7:0]  high_hold;
    logic        tbl_error;
    logic        enabled;
    logic        write_busy;
    logic        read_busy;
    logic [14:0] addr;
    logic [15:0] rdata;
    logic [1:0]  data_sync;
    logic [1:0]  clk_sync;
    logic        buf_wr;
    logic [15:0] buf_data;
    logic [5:0]  buf_idx;
  } pfa_reg_s;

  pfa_reg_s r;
  pfa_reg_s next_r;

  logic [15:0] wbuf [0:`PFA_PAGE_WORDS-1];

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // next address within page, holding at the last word
  function automatic logic [14:0] page_inc(input logic [14:0] a);
    if (a[5:0] == `PFA_PAGE_LAST) begin
      page_inc = a;
    end else begin
      page_inc = {a[14:6], a[5:0] + 6'h01};
    end
  endfunction

  // operation select field matches a code
  function automatic logic op_is(input pfa_ctrl_s c, input logic [2:0] code);
    op_is = c.op_select == code;
  endfunction

  // last cycle of an operation of the given length
  function automatic logic last_tick(input logic [7:0] cnt, input logic [7:0] len);
    last_tick = cnt == len - 8'h01;
  endfunction

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    next_r        = r;
    next_r.tbl_wr = 1'b0;
    next_r.buf_wr = 1'b0;
    next_r.data_sync = {r.data_sync[0], i_prog_serial_data_pin};
    next_r.clk_sync  = {r.clk_sync[0], i_prog_serial_clock_pin};
    if (i_flash_addr_load) begin
      next_r.addr = i_flash_addr;
    end
    if (i_ctrl.clear_enable) begin
      next_r.enabled = 1'b0;
    end else if (i_ctrl.enable_ok && op_is(i_ctrl, `PFA_OP_ENABLE)) begin
      next_r.enabled = 1'b1;
    end
    if (i_data_high_byte_wr && r.enabled && r.state == PFA_IDLE) begin
      next_r.buf_wr   = 1'b1;
      next_r.buf_data = {i_data_high_byte_reg, i_data_low_byte};
      next_r.buf_idx  = r.addr[5:0];
      next_r.addr     = page_inc(r.addr);
    end
    case (r.state)
      PFA_IDLE: begin
        next_r.count = 8'h00;
        if (i_tbl_req.valid) begin
          next_r.tbl_error = i_tbl_req.extended == i_tbl_req.sector0;
          next_r.dest      = i_tbl_req.dest_addr;
          next_r.state     = PFA_TBL;
        end else if (i_ctrl.write_start && r.enabled && op_is(i_ctrl, `PFA_OP_WRITE)) begin
          next_r.write_busy = 1'b1;
          next_r.state      = PFA_WRITE;
        end else if (i_ctrl.write_start && r.enabled && op_is(i_ctrl, `PFA_OP_ERASE)) begin
          next_r.write_busy = 1'b1;
          next_r.state      = PFA_ERASE;
        end else if (i_ctrl.read_start && i_ctrl.read_enable && op_is(i_ctrl, `PFA_OP_READ)) begin
          next_r.read_busy = 1'b1;
          next_r.state     = PFA_READ;
        end
      end
      PFA_TBL: begin
        next_r.count = r.count + 8'h01;
        if (last_tick(r.count, {6'h00, `PFA_TBL_CYCLES})) begin
          if (!r.tbl_error) begin
            next_r.tbl_wr    = 1'b1;
            next_r.low_byte  = i_flash_rdata[7:0];
            next_r.high_hold = i_flash_rdata[15:8];
          end
          next_r.state = PFA_IDLE;
        end
      end
      PFA_READ: begin
        next_r.count = r.count + 8'h01;
        if (last_tick(r.count, {4'h0, `PFA_READ_CYCLES})) begin
          next_r.rdata     = i_flash_rdata;
          next_r.read_busy = 1'b0;
          next_r.state     = PFA_IDLE;
        end
      end
      PFA_WRITE: begin
        next_r.count = r.count + 8'h01;
        if (last_tick(r.count, `PFA_WRITE_CYCLES)) begin
          next_r.write_busy = 1'b0;
          next_r.state      = PFA_IDLE;
        end
      end
      PFA_ERASE: begin
        next_r.count = r.count + 8'h01;
        if (last_tick(r.count, `PFA_ERASE_CYCLES)) begin
          next_r.write_busy = 1'b0;
          next_r.state      = PFA_IDLE;
        end
      end
      default: begin
        next_r.state = PFA_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // write buffer, one word per accepted high byte write
  always_ff @(posedge i_core_clk) begin
    if (r.buf_wr) begin
      wbuf[r.buf_idx] <= r.buf_data;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign o_tbl_wr                     = r.tbl_wr;
  assign o_tbl_dest_addr              = r.dest;
  assign o_tbl_low_byte               = r.low_byte;
  assign o_table_high_byte_holder     = r.high_hold;
  assign o_tbl_error                  = r.tbl_error;
  assign o_erase_write_enabled_status = r.enabled;
  assign o_write_start_bit            = r.write_busy;
  assign o_read_start_bit             = r.read_busy;
  assign o_flash_addr                 = r.addr;
  assign o_read_data                  = r.rdata;
  assign o_core_stall = r.state != PFA_IDLE;

  always_comb begin
    o_flash       = '0;
    o_flash.addr  = r.addr;
    o_flash.wdata = wbuf[r.count[5:0]];
    case (r.state)
      PFA_TBL: begin
        o_flash.rd   = 1'b1;
        o_flash.addr = {i_tbl_req.ptr_high, i_tbl_req.ptr_low};
      end
      PFA_READ: begin
        o_flash.rd = 1'b1;
      end
      PFA_WRITE: begin
        o_flash.wr   = r.count < 8'(`PFA_PAGE_WORDS);
        o_flash.addr = {r.addr[14:6], r.count[5:0]};
      end
      PFA_ERASE: begin
        o_flash.erase = r.count == 8'h00;
      end
      default: begin
        o_flash.rd = 1'b0;
      end
    endcase
  end

  // ----------------------------------------
  // pin mux
  // ----------------------------------------
  // debug or programming mode owns pins
  logic pins_owned;
  assign pins_owned = i_debug_active | i_prog_active;
  always_comb begin
    o_proto_data_in  = r.data_sync[1];
    o_proto_clock_in = r.clk_sync[1];
    // functions lose the pins while owned
    if (pins_owned) begin
      o_debug_serial_data_pin  = i_proto_data_out;
      o_debug_serial_data_oe   = i_proto_data_oe;
      o_debug_serial_clock_pin = 1'b0;
      o_debug_serial_clock_oe  = 1'b0;
      o_func_data_in           = 1'b0;
      o_func_clock_in          = 1'b0;
    end else begin
      o_debug_serial_data_pin  = i_func_data_out;
      o_debug_serial_data_oe   = i_func_data_oe;
      o_debug_serial_clock_pin = i_func_clock_out;
      o_debug_serial_clock_oe  = i_func_clock_oe;
      o_func_data_in           = r.data_sync[1];
      o_func_clock_in          = r.clk_sync[1];
    end
  end

endmodule

// File: bench/pfa_unit_sva.sv
// checker for the program flash access unit
`timescale 1ns/1ps
module pfa_unit_sva (
  // clock and reset
  input wire logic                  i_core_clk,
  input wire logic                  i_reset_n,
  // requests
  input wire pfa_pkg::pfa_tbl_req_s i_tbl_req,
  input wire pfa_pkg::pfa_ctrl_s    i_ctrl,
  input wire logic                  i_data_high_byte_wr,
  // status
  input wire logic                  o_tbl_wr,
  input wire logic                  o_core_stall,
  input wire logic                  o_read_start_bit,
  input wire logic                  o_write_start_bit,
  input wire logic                  o_erase_write_enabled_status,
  input wire logic [14:0]           o_flash_addr
);
  import pfa_pkg::*;
  logic [7:0] wcnt;
  logic       tk;
  logic       ok;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_reset_n);
  assign tk = i_tbl_req.valid && !o_core_stall;
  assign ok = i_tbl_req.extended != i_tbl_req.sector0;
  // ----
  // write busy length
  // ----
  always_ff @(posedge i_core_clk or negedge i_reset_n) begin
    if (!i_reset_n) wcnt <= 8'h00;
    else if (o_write_start_bit) wcnt <= wcnt + 8'h01;
    else wcnt <= 8'h00;
  end
  sequence s_tbl_run;
    o_core_stall [*2] ##1 (o_tbl_wr && !o_core_stall);
  endsequence
  a_tbl_two_cycles: assert property (tk && ok |=> s_tbl_run)
    else $error("table read timing wrong");
  a_tbl_refused: assert property (tk && !ok |=> !o_tbl_wr [*3])
    else $error("wrong sector table read wrote");
  a_read_gated: assert property (!o_core_stall && i_ctrl.read_start && !i_ctrl.read_enable |=> !o_read_start_bit)
    else $error("read ran while disabled");
  sequence s_read_run;
    o_read_start_bit [*4] ##1 !o_read_start_bit;
  endsequence
  a_read_length: assert property ($rose(o_read_start_bit) |-> s_read_run)
    else $error("read busy length wrong");
  a_write_length: assert property ($fell(o_write_start_bit) |-> wcnt == 8'h40)
    else $error("write busy length wrong");
  a_write_gated: assert property (!o_core_stall && i_ctrl.write_start && !o_erase_write_enabled_status
    |=> !o_write_start_bit)
    else $error("write ran while not enabled");
  a_enable_cause: assert property ($rose(o_erase_write_enabled_status)
    |-> $past(i_ctrl.enable_ok && i_ctrl.op_select == 3'h6))
    else $error("enabled status without cause");
  a_addr_stops: assert property (i_data_high_byte_wr && o_erase_write_enabled_status && !o_core_stall
    |=> o_flash_addr == ($past(o_flash_addr[5:0]) == 6'h3f ? $past(o_flash_addr) : $past(o_flash_addr) + 15'h0001))
    else $error("buffer address step wrong");
  a_busy_stalls: assert property (o_read_start_bit || o_write_start_bit |-> o_core_stall)
    else $error("core not halted while busy");
endmodule

// File: bench/pfa_flash_model.sv
// flash array model for the access unit bench
`timescale 1ns/1ps
module pfa_flash_model (
  // clock
  input  wire logic                i_core_clk,
  // array port
  input  wire pfa_pkg::pfa_flash_s i_flash,
  output logic [15:0]              o_rdata
);
  import pfa_pkg::*;
  logic [15:0] mem [int];
  logic [15:0] last = 16'h0000;
  function automatic logic [15:0] word_at(input logic [14:0] a);
    return mem.exists(a) ? mem[a] : {1'b0, a} ^ 16'h3c5a;
  endfunction
  // single word read, released data inverted
  always @* o_rdata = i_flash.rd ? word_at(i_flash.addr) : ~last;
  always @(posedge i_core_clk) begin
    if (i_flash.rd) last = word_at(i_flash.addr);
    if (i_flash.wr) mem[i_flash.addr] = i_flash.wdata;
    if (i_flash.erase) for (int i = 0; i < 64; i++) mem[{i_flash.addr[14:6], 6'(i)}] = 16'hffff;
  end
endmodule

// File: bench/pfa_unit_tb.sv
// testbench for the program flash access unit
`timescale 1ns/1ps
module pfa_unit_tb;
  import pfa_pkg::*;
  logic i_core_clk = '0, i_reset_n = '0, got;
  pfa_tbl_req_s i_tbl_req = '0;
  pfa_ctrl_s i_ctrl = '0;
  pfa_flash_s o_flash;
  logic [15:0] i_flash_rdata, o_read_data, expm [int], bufq [$];
  logic [14:0] i_flash_addr = '0, o_flash_addr;
  logic [7:0] i_data_low_byte = '0, i_data_high_byte_reg = '0, o_tbl_dest_addr, o_tbl_low_byte, o_table_high_byte_holder;
  logic i_flash_addr_load = '0, i_data_high_byte_wr = '0, i_debug_active = '0, i_prog_active = '0;
  logic i_prog_serial_data_pin = '0, i_prog_serial_clock_pin = '0, i_proto_data_out = '0, i_proto_data_oe = '0;
  logic i_func_data_out = '0, i_func_data_oe = '0, i_func_clock_out = '0, i_func_clock_oe = '0;
  logic o_tbl_wr, o_tbl_error, o_erase_write_enabled_status, o_write_start_bit, o_read_start_bit, o_core_stall;
  logic o_debug_serial_data_pin, o_debug_serial_data_oe, o_debug_serial_clock_pin, o_debug_serial_clock_oe;
  logic o_proto_data_in, o_proto_clock_in, o_func_data_in, o_func_clock_in;
  int fails = 0, checks_done = 0, seed = 67560;
  pfa_unit pfa_unit_i (
    .i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_tbl_req(i_tbl_req), .i_flash_rdata(i_flash_rdata),
    .o_tbl_wr(o_tbl_wr), .o_tbl_dest_addr(o_tbl_dest_addr), .o_tbl_low_byte(o_tbl_low_byte),
    .o_table_high_byte_holder(o_table_high_byte_holder), .o_tbl_error(o_tbl_error), .i_ctrl(i_ctrl),
    .i_flash_addr(i_flash_addr), .i_flash_addr_load(i_flash_addr_load), .i_data_low_byte(i_data_low_byte),
    .i_data_high_byte_wr(i_data_high_byte_wr), .i_data_high_byte_reg(i_data_high_byte_reg),
    .o_erase_write_enabled_status(o_erase_write_enabled_status), .o_write_start_bit(o_write_start_bit),
    .o_read_start_bit(o_read_start_bit), .o_flash_addr(o_flash_addr), .o_read_data(o_read_data),
    .o_core_stall(o_core_stall), .o_flash(o_flash), .i_debug_active(i_debug_active), .i_prog_active(i_prog_active),
    .i_prog_serial_data_pin(i_prog_serial_data_pin), .i_prog_serial_clock_pin(i_prog_serial_clock_pin),
    .i_proto_data_out(i_proto_data_out), .i_proto_data_oe(i_proto_data_oe), .i_func_data_out(i_func_data_out),
    .i_func_data_oe(i_func_data_oe), .i_func_clock_out(i_func_clock_out), .i_func_clock_oe(i_func_clock_oe),
    .o_debug_serial_data_pin(o_debug_serial_data_pin), .o_debug_serial_data_oe(o_debug_serial_data_oe),
    .o_debug_serial_clock_pin(o_debug_serial_clock_pin), .o_debug_serial_clock_oe(o_debug_serial_clock_oe),
    .o_proto_data_in(o_proto_data_in), .o_proto_clock_in(o_proto_clock_in), .o_func_data_in(o_func_data_in),
    .o_func_clock_in(o_func_clock_in)
  );
  pfa_flash_model pfa_flash_model_i (.i_core_clk, .i_flash(o_flash), .o_rdata(i_flash_rdata));
  always #4 i_core_clk = ~i_core_clk;
  // ----
  // helpers
  // ----
  task automatic chk(input string n, input logic [15:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge i_core_clk);
  endtask
  task automatic settle;
    int i;
    for (i = 0; i < 300 && o_core_stall !== 1'b0; i++) cyc(1);
    if (i == 300) begin
      fails++;
      complete_run;
    end
  endtask
  function automatic logic [15:0] exp_w(input logic [14:0] a);
    return expm.exists(a) ? expm[a] : {1'b0, a} ^ 16'h3c5a;
  endfunction
  task automatic addr(input logic [14:0] a);
    i_flash_addr = a;
    i_flash_addr_load = 1'b1;
    cyc(1);
    i_flash_addr_load = 1'b0;
  endtask
  // one start bit at a time; b is enable_ok, write, read enable, read start
  task automatic ctl(input logic [2:0] op, input logic [3:0] b);
    i_ctrl = {op, b[3], 1'b0, b[2:0]};
    cyc(1);
    i_ctrl = {op, 3'h0, b[1], 1'b0};
  endtask
  task automatic tbl(input logic ext, sec);
    logic [15:0] w;
    i_tbl_req = {1'b1, ext, sec, 23'($random(seed))};
    w = exp_w({i_tbl_req.ptr_high, i_tbl_req.ptr_low});
    got = 1'b0;
    for (int i = 0; i < 6 && !got; i++) begin
      cyc(1);
      got = o_tbl_wr;
    end
    if (ext != sec) begin
      chk("tbl_low", {got, o_tbl_low_byte}, {1'b1, w[7:0]});
      chk("tbl_high", o_table_high_byte_holder, w[15:8]);
      chk("tbl_dest", o_tbl_dest_addr, i_tbl_req.dest_addr);
    end else chk("tbl_err", {got, o_tbl_error}, 2'h1);
    i_tbl_req.valid = 1'b0;
    cyc(1);
  endtask
  // ----
  // main sequence
  // ----
  initial begin
    logic [14:0] pg;
    cyc(4);
    i_reset_n = 1'b1;
    cyc(1);
    chk("rst", {o_core_stall, o_write_start_bit, o_read_start_bit, o_erase_write_enabled_status}, 16'h0000);
    for (int k = 0; k < 9; k++) tbl(k[0], k < 6 ? ~k[0] : k[0]);
    addr(15'h1234);
    ctl(3'h3, 4'h1);
    chk("rd_gate", o_read_start_bit, 1'b0);
    settle;
    ctl(3'h3, 4'h3);
    chk("rd_busy", {o_read_start_bit, o_core_stall}, 2'h3);
    settle;
    chk("rd_data", o_read_data, exp_w(15'h1234));
    ctl(3'h0, 4'h4);
    chk("wr_gate", o_write_start_bit, 1'b0);
    settle;
    ctl(3'h6, 4'h8);
    chk("enabled", o_erase_write_enabled_status, 1'b1);
    ctl(3'h7, 4'h4);
    chk("rsvd_op", o_write_start_bit, 1'b0);
    pg = {9'($random(seed)), 6'h00};
    addr(pg);
    ctl(3'h1, 4'h4);
    chk("er_busy", o_write_start_bit, 1);
    settle;
    for (int i = 0; i < 64; i++) expm[pg + 15'(i)] = 16'hffff;
    addr(pg);
    i_data_high_byte_wr = 1'b1;
    for (int i = 0; i < 64; i++) begin
      {i_data_high_byte_reg, i_data_low_byte} = 16'($random(seed));
      bufq.push_back({i_data_high_byte_reg, i_data_low_byte});
      cyc(1);
    end
    i_data_high_byte_wr = 1'b0;
    chk("addr_end", o_flash_addr, pg | 15'h003f);
    addr(pg);
    ctl(3'h0, 4'h4);
    settle;
    for (int i = 0; i < 64; i++) expm[pg + 15'(i)] = bufq[i];
    for (int j = 0; j < 64; j += 21) begin
      addr(pg + 15'(j));
      ctl(3'h3, 4'h3);
      settle;
      chk("rd_back", o_read_data, exp_w(pg + 15'(j)));
    end
    i_ctrl.clear_enable = 1'b1;
    cyc(1);
    i_ctrl.clear_enable = 1'b0;
    chk("disabled", o_erase_write_enabled_status, 1'b0);
    i_data_high_byte_wr = 1'b1;
    cyc(1);
    i_data_high_byte_wr = 1'b0;
    chk("buf_gate", o_flash_addr, pg + 15'h003f);
    for (int k = 0; k < 4; k++) begin
      {i_debug_active, i_prog_active} = 2'(k);
      {i_proto_data_out, i_proto_data_oe, i_func_data_out, i_func_data_oe, i_func_clock_out, i_func_clock_oe,
        i_prog_serial_data_pin, i_prog_serial_clock_pin} = 8'($random(seed));
      cyc(2);
      chk("pin_data", {o_debug_serial_data_pin, o_debug_serial_data_oe},
        k ? {i_proto_data_out, i_proto_data_oe} : {i_func_data_out, i_func_data_oe});
      chk("clk_oe", o_debug_serial_clock_oe, k ? 1'b0 : i_func_clock_oe);
      chk("clk_pin", o_debug_serial_clock_pin, k ? 1'b0 : i_func_clock_out);
      chk("prog_in", {o_proto_data_in, o_proto_clock_in}, {i_prog_serial_data_pin, i_prog_serial_clock_pin});
      chk("func_in", {o_func_data_in, o_func_clock_in},
        k ? 2'h0 : {i_prog_serial_data_pin, i_prog_serial_clock_pin});
    end
    complete_run;
  end
endmodule
bind pfa_unit pfa_unit_sva pfa_unit_sva_i (
  .i_core_clk(i_core_clk), .i_reset_n(i_reset_n), .i_tbl_req(i_tbl_req), .i_ctrl(i_ctrl),
  .i_data_high_byte_wr(i_data_high_byte_wr), .o_tbl_wr(o_tbl_wr), .o_core_stall(o_core_stall),
  .o_read_start_bit(o_read_start_bit), .o_write_start_bit(o_write_start_bit),
  .o_erase_write_enabled_status(o_erase_write_enabled_status), .o_flash_addr(o_flash_addr)
);
